// >>> src/frg_pkg.sv
// Package of constants and carrier types for the frequency ramp generator
package frg_pkg;

    localparam int unsigned CLK_HZ        = 125000000;
    localparam int unsigned TICK_HZ       = 1000;
    localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W        = 17;
    // Frequencies in 0.01 Hz, times in 0.01 s; fraction bits for slope
    localparam int unsigned FREQ_W        = 16;
    localparam int unsigned TIME_W        = 16;
    localparam int unsigned FRAC_W        = 16;
    localparam int unsigned ACC_W         = FREQ_W + FRAC_W;
    localparam int unsigned TICKS_PER_CS  = TICK_HZ / 100;
    localparam logic [15:0] COARSE_MUL    = 16'h000a;
    localparam logic [15:0] FINE_MUL      = 16'h0001;
    localparam logic [15:0] TIME_MIN_C    = 16'h000a;
    localparam logic [15:0] TIME_MIN_F    = 16'h0001;
    localparam logic [15:0] TIME_MAX      = 16'hea60;
    localparam logic [15:0] JOG_TIME_RST  = 16'h0064;
    localparam logic [15:0] JOG_FREQ_RST  = 16'h0258;
    localparam logic [15:0] JOG_FREQ_MIN  = 16'h000a;
    localparam logic [15:0] SCURVE_MAX    = 16'h03e8;
    localparam logic [2:0]  FSRC1_RST     = 3'h1;
    localparam logic [2:0]  FSRC2_RST     = 3'h0;
    localparam logic [2:0]  RSRC_RST      = 3'h1;
    localparam logic [2:0]  FSRC_FORCED   = 3'h2;
    localparam logic [3:0]  FUNC_TSET     = 4'h7;

    typedef enum logic [2:0] {
        FRG_SRC_UPDOWN, FRG_SRC_VIN1, FRG_SRC_CUR_VIN2,
        FRG_SRC_SERIAL, FRG_SRC_POT, FRG_SRC_FIELDBUS
    } frg_fsrc_t;

    typedef enum logic [2:0] {
        FRG_MODE_LIN, FRG_MODE_AUTO_ACC, FRG_MODE_AUTO_DEC,
        FRG_MODE_AUTO_LOAD, FRG_MODE_AUTO_BOUND
    } frg_mode_t;

    typedef enum logic [1:0] {
        FRG_ST_IDLE, FRG_ST_RUN, FRG_ST_JOG
    } frg_state_t;

    // One acceleration/deceleration time pair
    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] dec;
    } frg_tpair_t;

    // Frequency command inputs from all sources
    typedef struct packed {
        logic [15:0] updown;
        logic [15:0] vin1;
        logic [15:0] current_in;
        logic [15:0] vin2;
        logic [15:0] serial;
        logic [15:0] pot;
        logic [15:0] fieldbus;
    } frg_fcmd_t;

    // Run command inputs from all sources
    typedef struct packed {
        logic key_run;
        logic key_stop;
        logic term_run;
        logic ser_run;
        logic fb_run;
    } frg_rcmd_t;

endpackage

// >>> src/frg_ramp.sv
// Frequency ramp generator: source select, time sets, jog and S-curve ramp
// Overview of operation
// - Accel time spans zero to maximum frequency
// - Decel time spans maximum frequency to zero
// - Partial spans take proportional time, same slope
// - Four time sets chosen by input terminals
// - Jog ramp times 0.1/0.01-600 s, default 1.0
// - Jog frequency 0.10 Hz to max, default 6.00
// - Jog on ramps min to jog frequency
// - Jog off ramps jog frequency to zero
// - Jog only when stopped; keypad keys only
// - Ramp mode field selects linear/automatic combinations
// - Mode 4 never faster than configured times
// - S-curve zero disables, nonzero smooths more
// - Total time is ramp time plus S-curve
// - First source resets to 1, second 0
// - Source 2 uses board switch for input
// - Third switch forces first source to 2
// - Terminal selects first or second source
// - Run source selector decodes six, resets 1
// - Ramp times 0.1/0.01 to 600.0 s
// - Two-bit TSET_SEL_I input selects one of the four time pairs
module frg_ramp #(
    parameter int unsigned TICK_CYC = frg_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic              REF_CLK_I,
    input  wire logic              RST_B_I,
    // Configuration
    input  wire logic [15:0]       MAX_FREQ_I,
    input  wire logic [15:0]       MIN_FREQ_I,
    input  wire logic              TIME_UNIT_FINE_I,
    input  wire frg_pkg::frg_tpair_t [3:0] TSET_I,
    input  wire logic [15:0]       JOG_ACC_I,
    input  wire logic [15:0]       JOG_DEC_I,
    input  wire logic [15:0]       JOG_FREQ_I,
    input  wire logic [2:0]        RAMP_MODE_I,
    input  wire logic [15:0]       SCURVE_ACC_I,
    input  wire logic [15:0]       SCURVE_DEC_I,
    input  wire logic [15:0]       AUTO_TIME_I,
    // Source selector writes
    input  wire logic              FSRC1_WR_I,
    input  wire logic              FSRC2_WR_I,
    input  wire logic              RSRC_WR_I,
    input  wire logic [2:0]        SRC_WDATA_I,
    // Board switches and terminals
    input  wire logic              SW_CUR_SEL_I,
    input  wire logic              SW_THIRD_I,
    input  wire logic [1:0]        TSET_SEL_I,
    input  wire logic              SRC_SECOND_I,
    input  wire logic              JOG_I,
    // Commands
    input  wire frg_pkg::frg_fcmd_t FCMD_I,
    input  wire frg_pkg::frg_rcmd_t RCMD_I,
    // Outputs
    output logic [15:0]            FREQ_REF_O,
    output logic                   RUNNING_O,
    output logic                   JOGGING_O,
    output logic                   AT_TARGET_O,
    output logic [2:0]             FSRC1_O,
    output logic [2:0]             FSRC2_O,
    output logic [2:0]             RSRC_O
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [16:0]           tick_cnt;
        logic                  tick;
        logic [2:0]            fsrc1;
        logic [2:0]            fsrc2;
        logic [2:0]            rsrc;
        frg_pkg::frg_state_t   state;
        logic [31:0]           acc;
        logic [15:0]           target;
        logic [15:0]           freq;
        logic                  running;
        logic                  jogging;
        logic                  at_target;
        logic                  jog_tail;
    } frg_st_t;

    frg_st_t st_reg;
    frg_st_t st_next;

    // Ramp time to hundredths of a second, clamped to the legal range
    function automatic logic [31:0] to_cs(input logic [15:0] t,
                                          input logic fine);
        logic [15:0] tmin;
        logic [31:0] cs;
        tmin = fine ? frg_pkg::TIME_MIN_F : frg_pkg::TIME_MIN_C;
        cs = {16'h0000, t};
        if (!fine) begin
            cs = 32'(cs * 32'(frg_pkg::COARSE_MUL));
        end
        // Floor is held in hundredths, so clamp after the unit scaling
        if (cs < {16'h0000, tmin}) begin
            cs = {16'h0000, tmin};
        end
        if (cs > 32'(frg_pkg::TIME_MAX)) begin
            cs = 32'(frg_pkg::TIME_MAX);
        end
        return cs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] src_val1;
    logic [15:0] src_val2;
    logic [15:0] cmd_freq;
    logic        run_req;
    logic        stop_req;
    logic [15:0] t_acc;
    logic [15:0] t_dec;
    logic [15:0] s_acc;
    logic [15:0] s_dec;
    logic [31:0] ramp_cs;
    logic [31:0] ticks;
    logic [47:0] step_w;
    logic [31:0] step;
    logic [31:0] tgt_fx;
    logic        up;
    logic [15:0] jog_f;

    function automatic logic [15:0] pick(input logic [2:0] s,
                                         input frg_pkg::frg_fcmd_t f,
                                         input logic cur);
        unique case (s)
            3'h0:    pick = f.updown;
            3'h1:    pick = f.vin1;
            3'h2:    pick = cur ? f.current_in : f.vin2;
            3'h3:    pick = f.serial;
            3'h4:    pick = f.pot;
            3'h5:    pick = f.fieldbus;
            default: pick = 16'h0000;
        endcase
    endfunction

    always_comb begin
        src_val1 = pick(st_reg.fsrc1, FCMD_I, SW_CUR_SEL_I);
        src_val2 = pick(st_reg.fsrc2, FCMD_I, SW_CUR_SEL_I);
        cmd_freq = SRC_SECOND_I ? src_val2 : src_val1;
        if (cmd_freq > MAX_FREQ_I) begin
            cmd_freq = MAX_FREQ_I;
        end
        // Run source decode; keypad stop honoured on 0, 1 and 3
        run_req  = 1'b0;
        stop_req = 1'b0;
        unique case (st_reg.rsrc)
            3'h0: begin
                run_req  = RCMD_I.key_run;
                stop_req = RCMD_I.key_stop;
            end
            3'h1: begin
                run_req  = RCMD_I.term_run;
                stop_req = RCMD_I.key_stop;
            end
            3'h2: run_req = RCMD_I.term_run;
            3'h3: begin
                run_req  = RCMD_I.ser_run;
                stop_req = RCMD_I.key_stop;
            end
            3'h4: run_req = RCMD_I.ser_run;
            3'h5: run_req = RCMD_I.fb_run;
            default: run_req = 1'b0;
        endcase
        jog_f = JOG_FREQ_I;
        if (jog_f < frg_pkg::JOG_FREQ_MIN) begin
            jog_f = frg_pkg::JOG_FREQ_MIN;
        end
        if (jog_f > MAX_FREQ_I) begin
            jog_f = MAX_FREQ_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next  = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt == 17'(TICK_CYC - 1)) begin
            st_next.tick_cnt = '0;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + 17'h00001;
        end

        if (SW_THIRD_I) begin
            st_next.fsrc1 = frg_pkg::FSRC_FORCED;
        end else if (FSRC1_WR_I && SRC_WDATA_I <= 3'h5) begin
            st_next.fsrc1 = SRC_WDATA_I;
        end
        if (FSRC2_WR_I && SRC_WDATA_I <= 3'h5) begin
            st_next.fsrc2 = SRC_WDATA_I;
        end
        if (RSRC_WR_I && SRC_WDATA_I <= 3'h5) begin
            st_next.rsrc = SRC_WDATA_I;
        end

        // Command state machine
        unique case (st_reg.state)
            frg_pkg::FRG_ST_IDLE: begin
                if (JOG_I && st_reg.freq == 16'h0000) begin
                    st_next.state = frg_pkg::FRG_ST_JOG;
                end else if (run_req && !stop_req) begin
                    st_next.state = frg_pkg::FRG_ST_RUN;
                end
            end
            frg_pkg::FRG_ST_RUN: begin
                if (!run_req || stop_req) begin
                    st_next.state = frg_pkg::FRG_ST_IDLE;
                end
            end
            frg_pkg::FRG_ST_JOG: begin
                // Only keypad stop can cut a jog short
                if (!JOG_I || RCMD_I.key_stop) begin
                    st_next.state = frg_pkg::FRG_ST_IDLE;
                end
            end
        endcase
        st_next.running = st_next.state != frg_pkg::FRG_ST_IDLE
                          || st_reg.freq != 16'h0000;
        st_next.jogging = st_next.state == frg_pkg::FRG_ST_JOG;
        // Jog times stay in force until the jog deceleration reaches zero or a run begins
        if (st_next.state == frg_pkg::FRG_ST_JOG) begin
            st_next.jog_tail = 1'b1;
        end else if (st_next.state == frg_pkg::FRG_ST_RUN ||
                     st_reg.acc == 32'h00000000) begin
            st_next.jog_tail = 1'b0;
        end

        unique case (st_reg.state)
            frg_pkg::FRG_ST_RUN: st_next.target = cmd_freq;
            frg_pkg::FRG_ST_JOG: st_next.target = jog_f;
            default:             st_next.target = 16'h0000;
        endcase

        // Time set select: TSET_SEL_I picks one of the four pairs
        t_acc = TSET_I[TSET_SEL_I].acc;
        t_dec = TSET_I[TSET_SEL_I].dec;
        if (st_reg.state == frg_pkg::FRG_ST_JOG || st_reg.jog_tail) begin
            t_acc = JOG_ACC_I;
            t_dec = JOG_DEC_I;
        end
        up = st_reg.target > st_reg.freq;
        s_acc = (SCURVE_ACC_I > frg_pkg::SCURVE_MAX) ? frg_pkg::SCURVE_MAX
                                                     : SCURVE_ACC_I;
        s_dec = (SCURVE_DEC_I > frg_pkg::SCURVE_MAX) ? frg_pkg::SCURVE_MAX
                                                     : SCURVE_DEC_I;
        ramp_cs = up ? to_cs(t_acc, TIME_UNIT_FINE_I)
                     : to_cs(t_dec, TIME_UNIT_FINE_I);
        // Automatic phases use the load-derived time; mode 4 floors it
        unique case (RAMP_MODE_I)
            3'h1: if (up) ramp_cs = to_cs(AUTO_TIME_I, TIME_UNIT_FINE_I);
            3'h2: if (!up) ramp_cs = to_cs(AUTO_TIME_I, TIME_UNIT_FINE_I);
            3'h3: ramp_cs = to_cs(AUTO_TIME_I, TIME_UNIT_FINE_I);
            3'h4: if (to_cs(AUTO_TIME_I, TIME_UNIT_FINE_I) > ramp_cs) begin
                ramp_cs = to_cs(AUTO_TIME_I, TIME_UNIT_FINE_I);
            end
            default: ramp_cs = ramp_cs;
        endcase
        // S-curve lengthens the total ramp by its own setting
        if (up && s_acc != 16'h0000) begin
            ramp_cs = 32'(ramp_cs + to_cs(s_acc, TIME_UNIT_FINE_I));
        end else if (!up && s_dec != 16'h0000) begin
            ramp_cs = 32'(ramp_cs + to_cs(s_dec, TIME_UNIT_FINE_I));
        end
        ticks  = 32'(ramp_cs * 32'(frg_pkg::TICKS_PER_CS));
        step_w = {16'h0000, MAX_FREQ_I, 16'h0000} / {16'h0000, ticks};
        step   = (step_w[47:32] != 16'h0000) ? 32'hffffffff : step_w[31:0];
        if (step == 32'h00000000) begin
            step = 32'h00000001;
        end
        tgt_fx = {st_reg.target, 16'h0000};

        // Fixed slope per tick, clamped at the target
        if (st_reg.tick) begin
            // Jog starts from the minimum frequency at its first tick
            if (st_reg.state == frg_pkg::FRG_ST_JOG &&
                    st_reg.acc < {MIN_FREQ_I, 16'h0000} &&
                    MIN_FREQ_I <= st_reg.target) begin
                st_next.acc = {MIN_FREQ_I, 16'h0000};
            end else if (st_reg.acc < tgt_fx) begin
                st_next.acc = (tgt_fx - st_reg.acc > step)
                              ? 32'(st_reg.acc + step) : tgt_fx;
            end else if (st_reg.acc > tgt_fx) begin
                st_next.acc = (st_reg.acc - tgt_fx > step)
                              ? 32'(st_reg.acc - step) : tgt_fx;
            end
        end
        st_next.freq      = st_next.acc[31:16];
        st_next.at_target = st_next.acc == {st_next.target, 16'h0000};
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_B_I) begin
            st_reg          <= '0;
            st_reg.fsrc1    <= frg_pkg::FSRC1_RST;
            st_reg.fsrc2    <= frg_pkg::FSRC2_RST;
            st_reg.rsrc     <= frg_pkg::RSRC_RST;
            st_reg.state    <= frg_pkg::FRG_ST_IDLE;
            st_reg.at_target <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign FREQ_REF_O  = st_reg.freq;
    assign RUNNING_O   = st_reg.running;
    assign JOGGING_O   = st_reg.jogging;
    assign AT_TARGET_O = st_reg.at_target;
    assign FSRC1_O     = st_reg.fsrc1;
    assign FSRC2_O     = st_reg.fsrc2;
    assign RSRC_O      = st_reg.rsrc;

    ////////////////////////////////////////////////////////////////////////
    a_forced_src: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        SW_THIRD_I |=> FSRC1_O == 3'h2)
        else $error("first source not forced while switch on");
    a_no_tick_move: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        !st_reg.tick |=> $stable(FREQ_REF_O))
        else $error("frequency moved without tick");
    a_jog_stopped: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        $rose(JOGGING_O) |-> $past(st_reg.freq) == 16'h0000)
        else $error("jog entered while not stopped");
    a_jog_release: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        (JOGGING_O && !JOG_I) |=> !JOGGING_O)
        else $error("jog held after release");
    a_no_overshoot: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        (st_reg.tick && st_reg.freq <= st_reg.target && up)
        |=> st_reg.freq <= $past(st_reg.target))
        else $error("ramp overshot target");
    a_stop_key: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        (st_reg.state == frg_pkg::FRG_ST_RUN && RCMD_I.key_stop &&
         st_reg.rsrc == 3'h1) |=> st_reg.state == frg_pkg::FRG_ST_IDLE)
        else $error("keypad stop ignored");
    a_idle_target: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        (st_reg.state == frg_pkg::FRG_ST_IDLE) |=> st_reg.target == 16'h0000)
        else $error("idle target not zero");
    a_rsrc_legal: assert property (@(posedge REF_CLK_I)
        disable iff (!RST_B_I)
        1'b1 |-> RSRC_O <= 3'h5 && FSRC2_O <= 3'h5)
        else $error("source selector out of range");

endmodule

// >>> verif/frg_cmd_src.sv
// Command source model: per-source frequencies and run requests
module frg_cmd_src (
    // Run and stop requests and the source that carries the run request
    input  wire logic         run_i,
    input  wire logic         stop_i,
    input  wire logic [2:0]   via_i,
    // Commands towards the ramp generator
    output frg_pkg::frg_fcmd_t fcmd_o,
    output frg_pkg::frg_rcmd_t rcmd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Every source carries a distinct value so a wrong pick shows
    always_comb begin
        fcmd_o.updown     = 16'h003c;
        fcmd_o.vin1       = 16'h0258;
        fcmd_o.current_in = 16'h0384;
        fcmd_o.vin2       = 16'h01c2;
        fcmd_o.serial     = 16'h012c;
        fcmd_o.pot        = 16'h00f0;
        fcmd_o.fieldbus   = 16'h0096;
    end

    ////////////////////////////////////////////////////////////////////////
    // Only the source named by via_i asserts its run line
    always_comb begin
        rcmd_o.key_run  = run_i && via_i == 3'h0;
        rcmd_o.key_stop = stop_i;
        rcmd_o.term_run = run_i && (via_i == 3'h1 || via_i == 3'h2);
        rcmd_o.ser_run  = run_i && (via_i == 3'h3 || via_i == 3'h4);
        rcmd_o.fb_run   = run_i && via_i == 3'h5;
    end
endmodule

// >>> verif/test_frg_ramp.sv
// Self-checking bench for the frequency ramp generator
module test_frg_ramp;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICK = 100;

    logic                      ref_clk = 1'b0;
    logic                      rst_b = 1'b0;
    logic                      fine = 1'b1;
    frg_pkg::frg_tpair_t [3:0] tset = {8{16'h000a}};
    logic [2:0]                mode = 3'h0;
    logic [15:0]               sc = 16'h0000;
    logic [15:0]               auto_t = 16'h0000;
    logic                      f1_wr = 1'b0;
    logic                      f2_wr = 1'b0;
    logic                      r_wr = 1'b0;
    logic [2:0]                wdata = 3'h0;
    logic                      sw_cur = 1'b0;
    logic                      sw_third = 1'b0;
    logic [1:0]                tsel = 2'h0;
    logic                      second = 1'b0;
    logic                      jog = 1'b0;
    logic                      run = 1'b0;
    logic                      stop = 1'b0;
    logic [2:0]                via = 3'h1;
    frg_pkg::frg_fcmd_t        fcmd;
    frg_pkg::frg_rcmd_t        rcmd;
    logic [15:0]               freq;
    logic                      running;
    logic                      jogging;
    logic                      at_tgt;
    logic [2:0]                fsrc1;
    logic [2:0]                fsrc2;
    logic [2:0]                rsrc;
    int                        n_errors = 0;
    int                        n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    frg_cmd_src src (.run_i(run), .stop_i(stop), .via_i(via), .fcmd_o(fcmd),
        .rcmd_o(rcmd));

    frg_ramp #(.TICK_CYC(TICK)) dut (
        .REF_CLK_I(ref_clk), .RST_B_I(rst_b), .MAX_FREQ_I(16'h1770),
        .MIN_FREQ_I(16'h0096), .TIME_UNIT_FINE_I(fine), .TSET_I(tset),
        .JOG_ACC_I(16'h000a), .JOG_DEC_I(16'h000a), .JOG_FREQ_I(16'h01e0),
        .RAMP_MODE_I(mode), .SCURVE_ACC_I(sc), .SCURVE_DEC_I(sc),
        .AUTO_TIME_I(auto_t), .FSRC1_WR_I(f1_wr), .FSRC2_WR_I(f2_wr),
        .RSRC_WR_I(r_wr), .SRC_WDATA_I(wdata), .SW_CUR_SEL_I(sw_cur),
        .SW_THIRD_I(sw_third), .TSET_SEL_I(tsel), .SRC_SECOND_I(second),
        .JOG_I(jog), .FCMD_I(fcmd), .RCMD_I(rcmd), .FREQ_REF_O(freq),
        .RUNNING_O(running), .JOGGING_O(jogging), .AT_TARGET_O(at_tgt),
        .FSRC1_O(fsrc1), .FSRC2_O(fsrc2), .RSRC_O(rsrc));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic sel_write(input int which, input logic [2:0] d);
        wdata = d;
        f1_wr = (which == 1);
        f2_wr = (which == 2);
        r_wr = (which == 3);
        @(negedge ref_clk);
        f1_wr = 1'b0;
        f2_wr = 1'b0;
        r_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic wait_freq(input logic [15:0] tgt);
        for (int i = 0; i < 30000 && freq !== tgt; i++) begin
            @(negedge ref_clk);
        end
        check(freq, tgt);
        if (freq !== tgt) tally_and_finish();
    endtask

    task automatic wait_run(input logic v);
        for (int i = 0; i < 3000 && running !== v; i++) begin
            @(negedge ref_clk);
        end
        check({15'h0, running}, {15'h0, v});
        if (running !== v) tally_and_finish();
    endtask

    // Counts the output steps until the target, flagging any overshoot
    task automatic steps(input logic [15:0] tgt, input int exp_n);
        logic [15:0] prev;
        logic        up;
        int          n;
        prev = freq;
        up = tgt > freq;
        n = 0;
        for (int i = 0; i < 30000 && freq !== tgt; i++) begin
            @(negedge ref_clk);
            if (freq !== prev) n++;
            if (up ? freq > tgt : freq < tgt) check(freq, tgt);
            prev = freq;
        end
        check(freq, tgt);
        check(n[15:0], exp_n[15:0]);
        if (freq !== tgt) tally_and_finish();
    endtask

    // One ramp up to 600 and back down to zero with the given settings
    task automatic run_case(input int s, f, a, d, c, m, au, ea, ed);
        tsel = s[1:0];
        fine = f[0];
        tset[s].acc = a[15:0];
        tset[s].dec = d[15:0];
        sc = c[15:0];
        mode = m[2:0];
        auto_t = au[15:0];
        run = 1'b1;
        steps(16'h0258, ea);
        repeat (2) @(negedge ref_clk);
        check({15'h0, at_tgt}, 16'h0001);
        run = 1'b0;
        steps(16'h0000, ed);
        wait_run(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check(freq, 16'h0000);
        check({15'h0, at_tgt}, 16'h0001);
        check({13'h0, fsrc1}, 16'h0001);
        check({13'h0, fsrc2}, 16'h0000);
        check({13'h0, rsrc}, 16'h0001);
        for (int v = 0; v < 6; v++) begin
            sel_write(2, v[2:0]);
            check({13'h0, fsrc2}, {13'h0, v[2:0]});
            sel_write(3, v[2:0]);
            check({13'h0, rsrc}, {13'h0, v[2:0]});
        end
        sel_write(3, 3'h6);
        check({13'h0, rsrc}, 16'h0005);
        sel_write(2, 3'h7);
        check({13'h0, fsrc2}, 16'h0005);
        sel_write(1, 3'h0);
        for (int v = 0; v < 6; v++) begin
            sel_write(3, v[2:0]);
            via = v[2:0];
            run = 1'b1;
            wait_run(1'b1);
            // Keypad stop counts only on run sources 0, 1 and 3
            stop = 1'b1;
            if (v == 0 || v == 1 || v == 3) begin
                wait_run(1'b0);
            end else begin
                repeat (3) @(negedge ref_clk);
                check({15'h0, running}, 16'h0001);
            end
            run = 1'b0;
            stop = 1'b0;
            wait_run(1'b0);
            wait_freq(16'h0000);
        end
        sel_write(3, 3'h1);
        via = 3'h1;
        sel_write(1, 3'h1);
        run_case(1, 1, 20, 10, 0, 0, 0, 20, 10);
        run_case(2, 1, 30, 10, 0, 0, 0, 30, 10);
        run_case(3, 1, 40, 10, 0, 0, 0, 40, 10);
        run_case(0, 0, 1, 2, 0, 0, 0, 10, 20);
        run_case(0, 1, 10, 10, 10, 0, 0, 20, 20);
        run_case(0, 1, 10, 10, 0, 4, 1, 10, 10);
        run_case(0, 1, 10, 10, 0, 4, 30, 30, 30);
        run_case(0, 1, 10, 10, 0, 1, 30, 30, 10);
        run_case(0, 1, 10, 10, 0, 2, 30, 10, 30);
        run_case(0, 1, 10, 10, 0, 3, 20, 20, 20);
        run_case(0, 1, 10, 10, 0, 0, 0, 10, 10);
        // Jog from standstill, run requests ignored meanwhile
        // Slower set-0 deceleration shows whether jog release uses jog time
        tset[0].dec = 16'h0014;
        jog = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({15'h0, jogging}, 16'h0001);
        wait_freq(16'h01e0);
        run = 1'b1;
        repeat (300) @(negedge ref_clk);
        check(freq, 16'h01e0);
        check({15'h0, jogging}, 16'h0001);
        run = 1'b0;
        jog = 1'b0;
        steps(16'h0000, 8);
        repeat (3) @(negedge ref_clk);
        check({15'h0, jogging}, 16'h0000);
        // Jog refused while running
        run = 1'b1;
        wait_freq(16'h0258);
        jog = 1'b1;
        repeat (5) @(negedge ref_clk);
        check({15'h0, jogging}, 16'h0000);
        jog = 1'b0;
        run = 1'b0;
        wait_freq(16'h0000);
        // Board switches and second source
        sel_write(2, 3'h4);
        sw_third = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({13'h0, fsrc1}, 16'h0002);
        sel_write(1, 3'h4);
        check({13'h0, fsrc1}, 16'h0002);
        sw_cur = 1'b1;
        run = 1'b1;
        wait_freq(16'h0384);
        sw_cur = 1'b0;
        wait_freq(16'h01c2);
        second = 1'b1;
        wait_freq(16'h00f0);
        run = 1'b0;
        wait_freq(16'h0000);
        second = 1'b0;
        sw_third = 1'b0;
        sel_write(1, 3'h1);
        check({13'h0, fsrc1}, 16'h0001);
        tally_and_finish();
    end
endmodule
